/* File: core/los_ref_pkg.sv */
// constants, register map and field layouts for the loss-of-signal and reference select block
// assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port
package los_ref_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_LOS_DETECT_COUNT  = 8'h00;
   localparam logic [7:0] ADDR_LOS_RECOVER_COUNT = 8'h04;
   localparam logic [7:0] ADDR_CONFIG            = 8'h08;
   localparam logic [7:0] ADDR_STATUS            = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK          = 8'h10;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_DETECT_COUNT  = 8'h0F;
   localparam logic [7:0]  RST_RECOVER_COUNT = 8'h0F;
   localparam logic [15:0] RST_CONFIG        = 16'h0000;
   localparam logic [1:0]  RST_IRQ_MASK      = 2'h3;

   // ----------------------------------------------------------------
   // config register field positions
   // ----------------------------------------------------------------
   localparam int CFG_DIGITAL_RX   = 0;
   localparam int CFG_LEVEL_LSB    = 1;
   localparam int CFG_CLEAR_LOSS   = 4;
   localparam int CFG_LONG_HAUL    = 5;
   localparam int CFG_CHG_IRQ_EN   = 6;
   localparam int CFG_CORNER       = 7;
   localparam int CFG_CENTRE_DIS   = 8;
   localparam int CFG_MASTER       = 9;
   localparam int CFG_SWITCH_DIS   = 10;
   localparam int CFG_SYNC_FREQ    = 11;
   localparam int CFG_SYNC_8K      = 12;
   localparam int CFG_OUT_SEL_LSB  = 13;
   localparam int CFG_FSYNC_EN     = 15;

   // status bits: 0 live loss, 1 sticky loss event, 2 sticky status change
   localparam int STS_LOS      = 0;
   localparam int STS_LOS_EVT  = 1;
   localparam int STS_CHG_EVT  = 2;

   localparam logic [12:0] DETECT_SCALE = 13'h0010;
   localparam int MISS_PERIODS = 3;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [3:0]
   {
      REF_LINE   = 4'b0001,
      REF_SYNC   = 4'b0010,
      REF_FREE   = 4'b0100,
      REF_CENTRE = 4'b1000
   } ref_src_t;

   typedef struct packed
   {
      logic       pos;
      logic       neg;
      logic       optical;
      logic [2:0] amplitude;
      logic       strobe;
   } rx_sample_t;

endpackage

/* File: core/los_ref_select.sv */
// loss-of-signal detector, receive oscillator reference select and clock routing
// assumes one rx_sample strobe per pulse period and sync/line edge strobes on ref_clk_i
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps

// Notes on behaviour
// - loss sets status bit, unmasked interrupt
// - optional interrupt on every status change
// - loss after N empty pulse periods
// - digital zero counts as absent pulse
// - analog pulse below level counts absent
// - N equals detect count times sixteen
// - recovery counts ones or strong pulses
// - alarm clears after recover count pulses
// - long haul blanks data on loss
// - oscillator locks line or sync input
// - buffer written line, read oscillator clock
// - oscillator clock routable to three pins
// - optional 8 kHz on frame sync; code gates the oscillator clock onto frame_sync_out_o instead
// - corner select lowers corner tenfold
// - recentre after missing reference periods
// - centre disable accepts gapped reference
// - gapped line clock only digital mode
// - slave tracks line, master behaviour on loss
// - switch disable keeps line during loss
// - master free-runs or locks to sync
// - sync frequency from two select bits
// - master with sync high centres
// - slave loss locks sync unless disabled; code centres or free-runs instead when 8 kHz sync is selected
module los_ref_select
   import los_ref_pkg::*;
#(
   parameter int MISS_LIMIT = MISS_PERIODS
)
(
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   input  wire rx_sample_t  rx_sample_i,
   input  wire logic        rx_data_i,
   input  wire logic        line_clk_edge_i,
   input  wire logic        sync_clk_edge_i,
   input  wire logic        osc_clk_i,
   input  wire logic        line_clk_i,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq_o,
   output logic             los_o,
   output logic             rx_data_o,
   output ref_src_t         ref_src_o,
   output logic             centre_o,
   output logic             corner_low_o,
   output logic [1:0]       sync_freq_o,
   output logic             buf_wr_clk_o,
   output logic             buf_rd_clk_o,
   output logic             rclk_o,
   output logic             aux_clock_out_o,
   output logic             system_rx_clock_o,
   output logic             frame_sync_out_o
);

   // ----------------------------------------------------------------
   // registers and bus slave
   // ----------------------------------------------------------------
   logic [7:0]  los_detect_count;
   logic [7:0]  los_recover_count;
   logic [15:0] config_reg;
   logic [2:0]  status;
   logic [1:0]  irq_mask;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;
   logic        clr_los_evt;
   logic        clr_chg_evt;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr[7:0];
         end
         else if (do_write)
            aw_held <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (do_write)
            w_held <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         // unmapped addresses answer with a slave error
         s_axi_bresp  <= (aw_addr > ADDR_IRQ_MASK || aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         los_detect_count  <= RST_DETECT_COUNT;
         los_recover_count <= RST_RECOVER_COUNT;
         config_reg        <= RST_CONFIG;
         irq_mask          <= RST_IRQ_MASK;
      end
      else if (do_write)
      begin
         unique case (aw_addr)
            ADDR_LOS_DETECT_COUNT:
               if (w_strb[0]) los_detect_count <= w_data[7:0];
            ADDR_LOS_RECOVER_COUNT:
               if (w_strb[0]) los_recover_count <= w_data[7:0];
            ADDR_CONFIG:
            begin
               if (w_strb[0]) config_reg[7:0]  <= w_data[7:0];
               if (w_strb[1]) config_reg[15:8] <= w_data[15:8];
            end
            ADDR_IRQ_MASK:
               if (w_strb[0]) irq_mask <= w_data[1:0];
            default: ;
         endcase
      end
   end

   // write one to clear sticky status
   assign clr_los_evt = do_write && aw_addr == ADDR_STATUS && w_strb[0] && w_data[STS_LOS_EVT];
   assign clr_chg_evt = do_write && aw_addr == ADDR_STATUS && w_strb[0] && w_data[STS_CHG_EVT];

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         unique case (s_axi_araddr[7:0])
            ADDR_LOS_DETECT_COUNT:  s_axi_rdata <= {24'h000000, los_detect_count};
            ADDR_LOS_RECOVER_COUNT: s_axi_rdata <= {24'h000000, los_recover_count};
            ADDR_CONFIG:            s_axi_rdata <= {16'h0000, config_reg};
            ADDR_STATUS:            s_axi_rdata <= {29'h00000000, status};
            ADDR_IRQ_MASK:          s_axi_rdata <= {30'h00000000, irq_mask};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ----------------------------------------------------------------
   // configuration fields
   // ----------------------------------------------------------------
   logic       digital_receive_select;
   logic [2:0] receive_input_level;
   logic       clear_data_on_loss;
   logic       long_haul;
   logic       status_change_irq_en;
   logic       corner_select;
   logic       centre_disable;
   logic       master_select;
   logic       loss_switch_disable;
   logic       sync_freq_select;
   logic       sync_8khz_select;
   logic [1:0] out_sel;
   logic       fsync_en;

   assign digital_receive_select = config_reg[CFG_DIGITAL_RX];
   assign receive_input_level    = config_reg[CFG_LEVEL_LSB +: 3];
   assign clear_data_on_loss     = config_reg[CFG_CLEAR_LOSS];
   assign long_haul              = config_reg[CFG_LONG_HAUL];
   assign status_change_irq_en   = config_reg[CFG_CHG_IRQ_EN];
   assign corner_select          = config_reg[CFG_CORNER];
   assign centre_disable         = config_reg[CFG_CENTRE_DIS];
   assign master_select          = config_reg[CFG_MASTER];
   assign loss_switch_disable    = config_reg[CFG_SWITCH_DIS];
   assign sync_freq_select       = config_reg[CFG_SYNC_FREQ];
   assign sync_8khz_select       = config_reg[CFG_SYNC_8K];
   assign out_sel                = config_reg[CFG_OUT_SEL_LSB +: 2];
   assign fsync_en               = config_reg[CFG_FSYNC_EN];

   // ----------------------------------------------------------------
   // loss-of-signal detection and recovery
   // ----------------------------------------------------------------
   logic        pulse_seen;
   logic [12:0] empty_cnt;
   logic [7:0]  recover_cnt;
   logic        los;
   logic        los_q;
   logic [12:0] detect_limit;

   always_comb
   begin
      if (digital_receive_select)
         pulse_seen = rx_sample_i.pos | rx_sample_i.neg | rx_sample_i.optical;
      else
         pulse_seen = rx_sample_i.amplitude > receive_input_level;
   end

   // zero register value treated as 256 so the range ends at 4096
   assign detect_limit = (los_detect_count == 8'h00) ? 13'h1000
                         : 13'({5'h00, los_detect_count} * DETECT_SCALE);

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         empty_cnt   <= 13'h0000;
         recover_cnt <= 8'h00;
         los         <= 1'b0;
      end
      else if (rx_sample_i.strobe)
      begin
         if (!los)
         begin
            if (pulse_seen)
               empty_cnt <= 13'h0000;
            else if (empty_cnt + 13'h0001 >= detect_limit)
            begin
               los         <= 1'b1;
               empty_cnt   <= 13'h0000;
               recover_cnt <= 8'h00;
            end
            else
               empty_cnt <= empty_cnt + 13'h0001;
         end
         else if (pulse_seen)
         begin
            // zero recover count behaves as one pulse
            if (recover_cnt + 8'h01 >= los_recover_count)
               los <= 1'b0;
            else
               recover_cnt <= recover_cnt + 8'h01;
         end
      end
   end

   // status bits: set wins over a clear in the same cycle
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         los_q  <= 1'b0;
         status <= 3'h0;
      end
      else
      begin
         los_q              <= los;
         status[STS_LOS]    <= los;
         if (los && !los_q)
            status[STS_LOS_EVT] <= 1'b1;
         else if (clr_los_evt)
            status[STS_LOS_EVT] <= 1'b0;
         if (los != los_q)
            status[STS_CHG_EVT] <= 1'b1;
         else if (clr_chg_evt)
            status[STS_CHG_EVT] <= 1'b0;
      end
   end

   assign irq_o = (status[STS_LOS_EVT] && !irq_mask[0])
                || (status[STS_CHG_EVT] && status_change_irq_en && !irq_mask[1]);
   assign los_o = los;

   // blanking acts on the raw detector, registered on the same edge as the status bit
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         rx_data_o <= 1'b0;
      else
         rx_data_o <= rx_data_i && !(long_haul && clear_data_on_loss && los);
   end

   // ----------------------------------------------------------------
   // reference watchdog and source select
   // ----------------------------------------------------------------
   logic [2:0] line_miss;
   logic [2:0] sync_miss;
   logic       line_lost;
   logic       sync_lost;
   ref_src_t   next_ref;

   // counts pulse periods (one per rx_sample strobe) with no reference edge
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         line_miss <= 3'h0;
         sync_miss <= 3'h0;
      end
      else if (rx_sample_i.strobe)
      begin
         line_miss <= line_clk_edge_i ? 3'h0 : (line_lost ? line_miss : line_miss + 3'h1);
         sync_miss <= sync_clk_edge_i ? 3'h0 : (sync_lost ? sync_miss : sync_miss + 3'h1);
      end
   end

   // analog line clock runs continuously, so only digital mode can miss
   assign line_lost = digital_receive_select && line_miss >= 3'(MISS_LIMIT);
   assign sync_lost = sync_miss >= 3'(MISS_LIMIT);

   always_comb
   begin
      next_ref = REF_LINE;
      if (master_select)
      begin
         if (!sync_lost)
            next_ref = REF_SYNC;
         else
            next_ref = centre_disable ? REF_FREE : REF_CENTRE;
      end
      else if (los && !loss_switch_disable)
      begin
         if (!sync_lost && !sync_8khz_select)
            next_ref = REF_SYNC;
         else
            next_ref = centre_disable ? REF_FREE : REF_CENTRE;
      end
      else if (line_lost && !centre_disable)
         next_ref = REF_CENTRE;
      else
         next_ref = REF_LINE;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         ref_src_o <= REF_LINE;
      else
         ref_src_o <= next_ref;
   end

   assign centre_o     = ref_src_o == REF_CENTRE;
   assign corner_low_o = corner_select;
   // 00 1.544 MHz, 01 2.048 MHz, 1x 8 kHz
   assign sync_freq_o  = {sync_8khz_select, sync_freq_select && !sync_8khz_select};

   // ----------------------------------------------------------------
   // clock routing
   // ----------------------------------------------------------------
   assign buf_wr_clk_o      = line_clk_i;
   assign buf_rd_clk_o      = osc_clk_i;
   assign rclk_o            = (out_sel == 2'h1) ? osc_clk_i : line_clk_i;
   assign aux_clock_out_o   = (out_sel == 2'h2) ? osc_clk_i : 1'b0;
   assign system_rx_clock_o = (out_sel == 2'h3) ? osc_clk_i : 1'b0;
   assign frame_sync_out_o  = fsync_en && osc_clk_i;

endmodule

/* File: tb/los_ref_select_checker.sv */
// port assertions for the loss-of-signal and reference select block
// assumes a bind onto los_ref_select, all signals seen by name
`timescale 1ns/10ps
module los_ref_select_checker
   import los_ref_pkg::*;
(
   input wire logic       ref_clk_i,
   input wire logic       nrst_i,
   input wire rx_sample_t rx_sample_i,
   input wire logic       rx_data_i,
   input wire logic       osc_clk_i,
   input wire logic       line_clk_i,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       irq_o,
   input wire logic       los_o,
   input wire logic       rx_data_o,
   input wire ref_src_t   ref_src_o,
   input wire logic       centre_o,
   input wire logic       corner_low_o,
   input wire logic       buf_wr_clk_o,
   input wire logic       buf_rd_clk_o,
   input wire logic       frame_sync_out_o
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid; endproperty
   a_wr_ans: assert property (p_wr_ans)
      else $error("write response late");
   property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_once: assert property (p_b_once)
      else $error("write response repeated");
   property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read response late");
   // alarm moves only in the cycles after a period strobe
   property p_los_edge; $changed(los_o)
      |-> $past(rx_sample_i.strobe) || $past(rx_sample_i.strobe, 2); endproperty
   a_los_edge: assert property (p_los_edge)
      else $error("alarm changed off strobe");
   property p_irq_fall; $fell(irq_o)
      |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3); endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt dropped without a write");
   property p_rx_pass; !los_o && !$past(los_o) && $past(nrst_i)
      |-> rx_data_o == $past(rx_data_i); endproperty
   a_rx_pass: assert property (p_rx_pass)
      else $error("data altered outside loss");
   property p_onehot; $onehot(ref_src_o); endproperty
   a_onehot: assert property (p_onehot)
      else $error("reference select not one-hot");
   property p_centre; centre_o == (ref_src_o == REF_CENTRE); endproperty
   a_centre: assert property (p_centre)
      else $error("centre flag disagrees");
   property p_buf_clk; buf_wr_clk_o == line_clk_i && buf_rd_clk_o == osc_clk_i; endproperty
   a_buf_clk: assert property (p_buf_clk)
      else $error("buffer clocks misrouted");
   property p_fsync; frame_sync_out_o |-> osc_clk_i; endproperty
   a_fsync: assert property (p_fsync)
      else $error("frame sync not from oscillator");
   property p_corner; $changed(corner_low_o)
      |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3); endproperty
   a_corner: assert property (p_corner)
      else $error("corner changed without a write");
endmodule

/* File: tb/line_rx_model.sv */
// line receiver and sync source model on the block's receive side
// assumes the bench sets pulse, amplitude and sync presence as levels
`timescale 1ns/10ps
module line_rx_model
   import los_ref_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       pulse_i,
   input  wire logic [2:0] amp_i,
   input  wire logic       sync_on_i,
   output rx_sample_t      sample_o,
   output logic            line_edge_o,
   output logic            sync_edge_o
);
   logic [1:0] phase;
   logic [5:0] junk;
   // one pulse period every four clocks
   always_ff @(posedge ref_clk_i)
   begin
      phase <= nrst_i ? phase + 2'h1 : 2'h0;
      junk  <= nrst_i ? ~junk : 6'h2A;
   end
   // off the strobe the fields toggle, so no stale value looks valid
   assign sample_o = (phase == 2'h3) ? {pulse_i, 2'h0, amp_i, 1'b1} : {junk, 1'b0};
   assign line_edge_o = (phase == 2'h3);
   // no edges while sync stands still, as if tied high
   assign sync_edge_o = (phase == 2'h3) && sync_on_i;
endmodule

/* File: tb/los_ref_select_tb.sv */
// self-checking bench for the loss-of-signal and reference select block
// assumes line_rx_model drives the receive side, checker bound below
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module los_ref_select_tb
   import los_ref_pkg::*;
();
   logic        ref_clk_i = 1'b0, nrst_i = 1'b0, osc_clk_i = 1'b0, line_clk_i = 1'b0;
   logic        rx_data_i = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        pulse = 1'b0, sync_on = 1'b1, dig = 1'b0;
   logic [2:0]  amp = 3'h0;
   rx_sample_t  rx_sample_i;
   logic        line_clk_edge_i, sync_clk_edge_i, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, irq_o, los_o, rx_data_o, centre_o, corner_low_o;
   logic        buf_wr_clk_o, buf_rd_clk_o, rclk_o, aux_clock_out_o, system_rx_clock_o;
   logic        frame_sync_out_o;
   logic [1:0]  s_axi_bresp, s_axi_rresp, sync_freq_o;
   logic [31:0] s_axi_rdata, seed = 32'h24DCA749;
   logic [33:0] exp_v, q[$], bq[$];
   ref_src_t    ref_src_o;
   int          bad_count = 0, n_checks = 0, tmo = 0;
   // reference table: config, sync present, pulses present, expected source
   logic [15:0] rcfg [6] = '{16'h0006, 16'h0006, 16'h0406, 16'h0206, 16'h0206, 16'h0306};
   logic [0:5]  rsy = 6'h3C, rpr = 6'h27;
   ref_src_t    rexp [6] = '{REF_LINE, REF_SYNC, REF_LINE, REF_SYNC, REF_CENTRE, REF_FREE};

   los_ref_select i_los_ref_select (.*);
   line_rx_model i_line_rx_model (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .pulse_i(pulse),
      .amp_i(amp), .sync_on_i(sync_on), .sample_o(rx_sample_i),
      .line_edge_o(line_clk_edge_i), .sync_edge_o(sync_clk_edge_i));

   // ----------------------------------------
   // clock, random inputs, timeout, results
   // ----------------------------------------
   initial forever #5 ref_clk_i = ~ref_clk_i;
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] r;
      r = v ^ (v << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction
   always @(posedge ref_clk_i)
   begin
      seed <= xs(seed);
      osc_clk_i <= seed[0];
      line_clk_i <= seed[1];
      rx_data_i <= seed[2];
      tmo <= tmo + 1;
      if (tmo == 20000)
      begin
         bad_count++;
         print_verdict();
      end
   end
   // sampled mid-cycle so the handshake edge itself is never raced
   always @(negedge ref_clk_i)
   begin
      if (s_axi_rvalid && s_axi_rready)
      begin
         exp_v = (q.size() > 0) ? q.pop_front() : 34'h3FFFFFFFF;
         `CHK({s_axi_rresp, s_axi_rdata}, exp_v)
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
         exp_v = (bq.size() > 0) ? bq.pop_front() : 34'h3FFFFFFFF;
         `CHK(s_axi_bresp, exp_v[1:0])
      end
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic da, dw;
      @(posedge ref_clk_i);
      // unmapped or misaligned offsets answer with a slave error
      bq.push_back((a > ADDR_IRQ_MASK || a[1:0] != 2'h0) ? 34'h2 : 34'h0);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      {da, dw} = 2'b00;
      while (!(da && dw))
      begin
         @(negedge ref_clk_i);
         da = da || s_axi_awready;
         dw = dw || s_axi_wready;
         @(posedge ref_clk_i);
         if (da) s_axi_awvalid <= 1'b0;
         if (dw) s_axi_wvalid <= 1'b0;
      end
      do @(negedge ref_clk_i); while (!s_axi_bvalid);
      @(posedge ref_clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      @(posedge ref_clk_i);
      q.push_back(e);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      do @(negedge ref_clk_i); while (!s_axi_arready);
      @(posedge ref_clk_i);
      s_axi_arvalid <= 1'b0;
      do @(negedge ref_clk_i); while (!s_axi_rvalid);
      @(posedge ref_clk_i);
   endtask
   // n pulse periods, with or without a pulse; analog relies on level 3
   task automatic per(input int n, input logic p);
      pulse <= dig ? p : !p;
      amp <= dig ? (p ? 3'h0 : 3'h7) : (p ? 3'h4 : 3'h3);
      repeat (n)
      begin
         do @(negedge ref_clk_i); while (!rx_sample_i.strobe);
         @(posedge ref_clk_i);
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      wr(8'h14, 32'hFFFF);
      rd(ADDR_LOS_DETECT_COUNT, {26'h0, RST_DETECT_COUNT});
      rd(ADDR_LOS_RECOVER_COUNT, {26'h0, RST_RECOVER_COUNT});
      rd(ADDR_CONFIG, {18'h0, RST_CONFIG});
      rd(ADDR_IRQ_MASK, 34'h3);
      rd(8'h14, {2'b10, 32'h0});
      rd(8'h02, {2'b10, 32'h0});
      $display("test register map done");
      // mode 0 analog, change irq only; mode 1 digital, blanking, loss irq only
      for (int m = 0; m < 2; m++)
      begin
         dig = m[0];
         wr(ADDR_LOS_DETECT_COUNT, 32'(m + 1));
         wr(ADDR_LOS_RECOVER_COUNT, 32'h2);
         wr(ADDR_CONFIG, m ? 32'h0037 : 32'h0046);
         wr(ADDR_IRQ_MASK, 32'(m + 1));
         wr(ADDR_STATUS, 32'h6);
         rd(ADDR_LOS_DETECT_COUNT, 34'(m + 1));
         per(3, 1);
         per(10, 0);
         per(1, 1);
         per((m + 1) * 16 - 1, 0);
         settle();
         `CHK(los_o, 1'b0)
         per(1, 0);
         settle();
         `CHK(los_o, 1'b1)
         `CHK(irq_o, 1'b1)
         for (int k = 0; k < 4 * m; k++)
         begin
            @(negedge ref_clk_i);
            `CHK(rx_data_o, 1'b0)
         end
         if (m == 0) rd(ADDR_STATUS, 34'h7);
         wr(ADDR_STATUS, 32'h6);
         #1;
         `CHK(irq_o, 1'b0)
         per(1, 1);
         settle();
         `CHK(los_o, 1'b1)
         per(1, 1);
         settle();
         `CHK(los_o, 1'b0)
         `CHK(irq_o, !m[0])
         if (m == 0) rd(ADDR_STATUS, 34'h4);
         $display("test loss mode %0d done", m);
      end
      dig = 1'b0;
      for (int k = 0; k < 6; k++)
      begin
         wr(ADDR_CONFIG, {16'h0, rcfg[k]});
         sync_on <= rsy[k];
         per(40, rpr[k]);
         settle();
         `CHK(ref_src_o, rexp[k])
      end
      $display("test reference select done");
      for (int c = 0; c < 4; c++)
      begin
         wr(ADDR_CONFIG, (c << CFG_SYNC_FREQ) | (c << CFG_OUT_SEL_LSB)
            | (c[0] << CFG_FSYNC_EN) | (c[0] << CFG_CORNER));
         repeat (2) @(negedge ref_clk_i);
         `CHK(sync_freq_o, c[1] ? 2'h2 : {1'b0, c[0]})
         `CHK(corner_low_o, c[0])
         `CHK(frame_sync_out_o, c[0] & osc_clk_i)
         `CHK(rclk_o, c == 1 ? osc_clk_i : line_clk_i)
         `CHK(aux_clock_out_o, c == 2 && osc_clk_i)
         `CHK(system_rx_clock_o, c == 3 && osc_clk_i)
      end
      $display("test clock routing done");
      print_verdict();
   end
endmodule

bind los_ref_select los_ref_select_checker i_los_ref_select_checker (.*);
